/* hw/mim_consts.svh */
`ifndef MIM_CONSTS_SVH
`define MIM_CONSTS_SVH

// ----------------------------------------------------------------------
// Peripheral register addresses
// ----------------------------------------------------------------------
`define MIM_A_KEY 8'he0
`define MIM_A_SW_LO 8'he2
`define MIM_A_SW_HI 8'he3
`define MIM_A_TAPS 8'he4
`define MIM_A_KEY_EN 8'he8
`define MIM_A_SW_EN 8'hea
`define MIM_A_TM_EN 8'heb
`define MIM_A_KEY_CAUSE 8'hed
`define MIM_A_SW_CAUSE 8'hee
`define MIM_A_TM_CAUSE 8'hef
`define MIM_A_OUT 8'hf3
`define MIM_A_BIDIR 8'hf6
`define MIM_A_TIMER_CTL 8'hf9
`define MIM_A_SUPPLY 8'hfa
`define MIM_A_DRIVE 8'hfb
`define MIM_A_DIR 8'hfc
`define MIM_A_TONE 8'hfd

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MIM_B_SW_CLEAR 0
`define MIM_B_SW_GO 1
`define MIM_B_TM_CLEAR 2
`define MIM_B_SUPPLY_ON 0
`define MIM_B_SUPPLY_LOW 1
`define MIM_B_HEAVY 3
`define MIM_B_STATIC 3
`define MIM_B_DIR 0
`define MIM_B_TONE 3
`define MIM_B_FREQ_ON 0
`define MIM_B_BUZZ_ON 1

// ----------------------------------------------------------------------
// Memory organisation and reset values
// ----------------------------------------------------------------------
`define MIM_RAM_BASE 8'h00
`define MIM_RAM_WORDS 80
`define MIM_DISP_BASE 8'hc0
`define MIM_DISP_WORDS 32
`define MIM_SHORT_LAST 8'h0f
`define MIM_PROG_PAGE_BITS 2
`define MIM_STACK_WORDS 8'h03
`define MIM_BOOT_STEP 8'h00
`define MIM_BOOT_PAGE 4'h1
`define MIM_BOOT_NPP 4'h1
`define MIM_REG_RESET 4'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MIM_CLK_HZ 10000000
`define MIM_KEY_RESET_MS 4000
`define MIM_TIMER_TICK_HZ 256
`define MIM_SW_TICK_HZ 100

`endif

/* hw/mim_divider.sv */
`timescale 1ns/10ps
module mim_divider #(
  parameter int DIV = 39062
) (
  input logic clk,
  input logic reset,
  output logic tick
);
  import mim_pkg::*;

  localparam int CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } mim_div_t;

  mim_div_t r;
  mim_div_t next_r;

  if (DIV < 2) begin : g_chk
    $error("mim_divider needs DIV of at least 2");
  end

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.count == CW'(DIV - 1)) begin
      next_r.count = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.count = r.count + CW'(1);
    end
    if (reset) begin
      next_r = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign tick = r.tick;
endmodule : mim_divider

/* hw/mim_io_map.sv */
`timescale 1ns/10ps
`include "mim_consts.svh"
module mim_io_map #(
  parameter int KEY_RESET_CYCLES = `MIM_KEY_RESET_MS * (`MIM_CLK_HZ / 1000),
  parameter int TIMER_DIV = `MIM_CLK_HZ / `MIM_TIMER_TICK_HZ,
  parameter int SW_DIV = `MIM_CLK_HZ / `MIM_SW_TICK_HZ,
  parameter logic [3:0] KEY_COMBO = 4'hf,
  parameter bit FREQ_SPECIAL = 1'b1,
  parameter bit BUZZ_SPECIAL = 1'b1,
  parameter int FREQ_TAP = 12,
  parameter int BUZZ_TAP = 10
) (
  input logic clk,
  input logic reset,
  input logic [7:0] addr,
  input logic rd_en,
  input logic wr_en,
  input logic [3:0] wdata,
  output logic [3:0] rdata,
  input logic [3:0] key_inputs,
  input logic [3:0] bidir_pins_in,
  output logic [3:0] bidir_pins_out,
  output logic [3:0] bidir_pins_oe_n,
  input logic supply_low_in,
  output logic [3:0] output_pins,
  output logic heavy_load_guard,
  output logic supply_check_on,
  output logic static_drive_select,
  output logic core_reset,
  output logic [7:0] boot_step,
  output logic [3:0] boot_page,
  output logic [3:0] boot_next_page,
  input logic [3:0] fetch_page,
  input logic [7:0] fetch_step,
  output logic [9:0] fetch_addr,
  input logic [3:0] short_ptr,
  output logic [7:0] short_addr,
  input logic stack_push,
  input logic stack_pop,
  output logic [7:0] stack_ptr
);
  import mim_pkg::*;

  localparam int RAMW = `MIM_RAM_WORDS;
  localparam int DISPW = `MIM_DISP_WORDS;

  if (KEY_RESET_CYCLES < 1 || KEY_RESET_CYCLES >= 2 ** 26 || FREQ_TAP < 3 ||
      FREQ_TAP > 15 || BUZZ_TAP > 14 || BUZZ_TAP < 0) begin : g_chk
    $error("mim_io_map parameters out of range");
  end

  typedef struct packed {
    mim_key_state_t kstate;
    logic [25:0] kcount;
    logic core_reset;
    logic [3:0] rdata;
    logic [3:0] key_en;
    logic [1:0] sw_en;
    logic [2:0] tm_en;
    logic key_cause;
    logic [1:0] sw_cause;
    logic [2:0] tm_cause;
    logic [3:0] key_seen;
    logic [7:0] ctimer;
    logic [3:0] sw_lo;
    logic [3:0] sw_hi;
    logic sw_run;
    logic [3:0] out_reg;
    logic [3:0] out_pins;
    logic [3:0] bidir_reg;
    logic [3:0] bidir_oe_n;
    logic heavy;
    logic sv_on;
    logic static_drv;
    logic [1:0] fsel;
    logic tone;
    logic [15:0] fast;
    logic [7:0] sp;
    logic [9:0] fetch_addr;
    logic [7:0] short_addr;
    logic [7:0] boot_step;
    logic [3:0] boot_page;
    logic [3:0] boot_npp;
    logic [RAMW-1:0][3:0] ram;
    logic [DISPW-1:0][3:0] disp;
  } mim_state_t;

  mim_state_t r;
  mim_state_t next_r;

  // ----------------------------------------------------------------------
  // Pin synchronisers and time bases
  // ----------------------------------------------------------------------
  logic [8:0] pins_q;
  logic tm_tick;
  logic sw_tick;
  logic init;

  mim_sync3 #(.WIDTH(9)) u_sync (
    .clk(clk),
    .reset(reset),
    .din({supply_low_in, bidir_pins_in, key_inputs}),
    .dout(pins_q)
  );

  mim_divider #(.DIV(TIMER_DIV)) u_tm_div (
    .clk(clk),
    .reset(init),
    .tick(tm_tick)
  );

  mim_divider #(.DIV(SW_DIV)) u_sw_div (
    .clk(clk),
    .reset(init),
    .tick(sw_tick)
  );

  // The key reset feeds back one cycle late through a flop so the detector
  // itself is never cleared by its own output.
  assign init = reset | r.core_reset;

  function automatic mim_region_t region(input logic [7:0] a);
    if (a < `MIM_RAM_BASE + 8'(RAMW)) begin
      return MIM_R_RAM;
    end else if (a >= `MIM_DISP_BASE && a < `MIM_DISP_BASE + 8'(DISPW)) begin
      return MIM_R_DISP;
    end else if (a >= `MIM_A_KEY) begin
      return MIM_R_IO;
    end
    return MIM_R_NONE;
  endfunction : region

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic [3:0] keys;
  logic [3:0] key_live;
  logic combo_held;
  logic [7:0] ct_next;
  logic [7:0] ct_fall;
  logic sw_tenth_evt;
  logic sw_second_evt;
  logic [3:0] rd_val;
  logic rd_hit;

  always_comb begin
    next_r = r;
    keys = pins_q[3:0];
    key_live = keys & r.key_en;
    combo_held = (KEY_COMBO != 4'h0) && ((keys & KEY_COMBO) == KEY_COMBO);
    ct_next = r.ctimer;
    sw_tenth_evt = 1'b0;
    sw_second_evt = 1'b0;
    rd_val = 4'h0;
    rd_hit = rd_en && (region(addr) == MIM_R_IO);

    case (r.kstate)
      MIM_K_IDLE: begin
        next_r.kcount = '0;
        if (combo_held) begin
          next_r.kstate = MIM_K_COUNT;
        end
      end
      MIM_K_COUNT: begin
        next_r.kcount = r.kcount + 26'h1;
        if (!combo_held) begin
          next_r.kstate = MIM_K_IDLE;
        end else if (r.kcount == 26'(KEY_RESET_CYCLES - 1)) begin
          next_r.kstate = MIM_K_FIRED;
        end
      end
      MIM_K_FIRED: begin
        if (!combo_held) begin
          next_r.kstate = MIM_K_IDLE;
        end
      end
      default: begin
        next_r.kstate = MIM_K_IDLE;
      end
    endcase
    next_r.core_reset = (next_r.kstate == MIM_K_FIRED);

    if (tm_tick) begin
      ct_next = r.ctimer + 8'h01;
    end
    ct_fall = r.ctimer & ~ct_next;
    next_r.ctimer = ct_next;

    if (sw_tick && r.sw_run) begin
      if (r.sw_lo == 4'h9) begin
        next_r.sw_lo = 4'h0;
        sw_tenth_evt = 1'b1;
        if (r.sw_hi == 4'h9) begin
          next_r.sw_hi = 4'h0;
          sw_second_evt = 1'b1;
        end else begin
          next_r.sw_hi = r.sw_hi + 4'h1;
        end
      end else begin
        next_r.sw_lo = r.sw_lo + 4'h1;
      end
    end

    // Read mux; only implemented bits are placed, the rest stay zero.
    // unused bits read zero
    case (region(addr))
      MIM_R_RAM: rd_val = r.ram[addr];
      MIM_R_DISP: rd_val = r.disp[addr - `MIM_DISP_BASE];
      MIM_R_IO: begin
        case (addr)
          `MIM_A_KEY: rd_val = keys;
          `MIM_A_SW_LO: rd_val = r.sw_lo;
          `MIM_A_SW_HI: rd_val = r.sw_hi;
          `MIM_A_TAPS: rd_val = r.ctimer[6:3];
          `MIM_A_KEY_EN: rd_val = r.key_en;
          `MIM_A_SW_EN: rd_val = {2'b00, r.sw_en};
          `MIM_A_TM_EN: rd_val = {1'b0, r.tm_en};
          `MIM_A_KEY_CAUSE: rd_val = {3'b000, r.key_cause};
          `MIM_A_SW_CAUSE: rd_val = {2'b00, r.sw_cause};
          `MIM_A_TM_CAUSE: rd_val = {1'b0, r.tm_cause};
          `MIM_A_OUT: rd_val = r.out_reg;
          `MIM_A_BIDIR: rd_val = r.bidir_oe_n[0] ? pins_q[7:4] : r.bidir_reg;
          `MIM_A_TIMER_CTL: rd_val = {2'b00, r.sw_run, 1'b0};
          `MIM_A_SUPPLY: rd_val = {r.heavy, 1'b0, pins_q[8] & r.sv_on, r.sv_on};
          `MIM_A_DRIVE: rd_val = {r.static_drv, 3'b000};
          `MIM_A_DIR: rd_val = {3'b000, ~r.bidir_oe_n[0]};
          `MIM_A_TONE: rd_val = {r.tone, 1'b0, r.fsel};
          default: rd_val = 4'h0;
        endcase
      end
      default: rd_val = 4'h0;
    endcase
    if (rd_en) begin
      next_r.rdata = rd_val;
    end

    // clear on read, a new event wins
    next_r.key_seen = key_live;
    next_r.key_cause = (rd_hit && addr == `MIM_A_KEY_CAUSE) ? 1'b0 : r.key_cause;
    next_r.sw_cause = (rd_hit && addr == `MIM_A_SW_CAUSE) ? 2'b00 : r.sw_cause;
    next_r.tm_cause = (rd_hit && addr == `MIM_A_TM_CAUSE) ? 3'b000 : r.tm_cause;
    if (|(key_live & ~r.key_seen)) begin
      next_r.key_cause = 1'b1;
    end
    next_r.sw_cause = next_r.sw_cause | {sw_second_evt, sw_tenth_evt};
    next_r.tm_cause = next_r.tm_cause | {ct_fall[6], ct_fall[4], ct_fall[2]};

    if (wr_en) begin
      case (region(addr))
        MIM_R_RAM: next_r.ram[addr] = wdata;
        MIM_R_DISP: next_r.disp[addr - `MIM_DISP_BASE] = wdata;
        MIM_R_IO: begin
          case (addr)
            `MIM_A_KEY_EN: next_r.key_en = wdata;
            `MIM_A_SW_EN: next_r.sw_en = wdata[1:0];
            `MIM_A_TM_EN: next_r.tm_en = wdata[2:0];
            `MIM_A_OUT: next_r.out_reg = wdata;
            `MIM_A_BIDIR: next_r.bidir_reg = wdata;
            `MIM_A_TIMER_CTL: begin
              next_r.sw_run = wdata[`MIM_B_SW_GO];
              if (wdata[`MIM_B_SW_CLEAR]) begin
                next_r.sw_lo = 4'h0;
                next_r.sw_hi = 4'h0;
              end
              if (wdata[`MIM_B_TM_CLEAR]) begin
                next_r.ctimer = 8'h00;
              end
            end
            `MIM_A_SUPPLY: begin
              next_r.heavy = wdata[`MIM_B_HEAVY];
              next_r.sv_on = wdata[`MIM_B_SUPPLY_ON];
            end
            `MIM_A_DRIVE: next_r.static_drv = wdata[`MIM_B_STATIC];
            `MIM_A_DIR: next_r.bidir_oe_n = {4{~wdata[`MIM_B_DIR]}};
            `MIM_A_TONE: begin
              next_r.tone = wdata[`MIM_B_TONE];
              next_r.fsel = wdata[1:0];
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    // tones derived from the one clock
    next_r.fast = r.fast + 16'h0001;
    next_r.out_pins = next_r.out_reg;
    if (FREQ_SPECIAL) begin
      next_r.out_pins[0] = next_r.out_reg[`MIM_B_FREQ_ON] & r.fast[FREQ_TAP - r.fsel];
    end
    if (BUZZ_SPECIAL) begin
      next_r.out_pins[1] = next_r.out_reg[`MIM_B_BUZZ_ON] & r.fast[BUZZ_TAP + r.tone];
    end

    if (stack_push && !stack_pop) begin
      next_r.sp = r.sp - `MIM_STACK_WORDS;
    end else if (stack_pop && !stack_push) begin
      next_r.sp = r.sp + `MIM_STACK_WORDS;
    end
    next_r.fetch_addr = {fetch_page[`MIM_PROG_PAGE_BITS-1:0], fetch_step};
    next_r.short_addr = {4'h0, short_ptr};

    if (init) begin
      next_r.rdata = 4'h0;
      next_r.key_en = `MIM_REG_RESET;
      next_r.sw_en = 2'b00;
      next_r.tm_en = 3'b000;
      next_r.key_cause = 1'b0;
      next_r.sw_cause = 2'b00;
      next_r.tm_cause = 3'b000;
      next_r.key_seen = 4'h0;
      next_r.ctimer = 8'h00;
      next_r.sw_lo = `MIM_REG_RESET;
      next_r.sw_hi = `MIM_REG_RESET;
      next_r.sw_run = 1'b0;
      next_r.out_reg = `MIM_REG_RESET;
      next_r.out_pins = 4'h0;
      next_r.bidir_reg = `MIM_REG_RESET;
      next_r.bidir_oe_n = 4'hf;
      next_r.heavy = 1'b0;
      next_r.sv_on = 1'b0;
      next_r.static_drv = 1'b0;
      next_r.fsel = 2'b00;
      next_r.tone = 1'b0;
      next_r.sp = 8'h00;
      next_r.boot_step = `MIM_BOOT_STEP;
      next_r.boot_page = `MIM_BOOT_PAGE;
      next_r.boot_npp = `MIM_BOOT_NPP;
    end
    if (reset) begin
      next_r.kstate = MIM_K_IDLE;
      next_r.kcount = '0;
      next_r.core_reset = 1'b1;
      next_r.fast = 16'h0000;
      next_r.fetch_addr = 10'h000;
      next_r.short_addr = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign rdata = r.rdata;
  assign bidir_pins_out = r.bidir_reg;
  assign bidir_pins_oe_n = r.bidir_oe_n;
  assign output_pins = r.out_pins;
  assign heavy_load_guard = r.heavy;
  assign supply_check_on = r.sv_on;
  assign static_drive_select = r.static_drv;
  assign core_reset = r.core_reset;
  assign boot_step = r.boot_step;
  assign boot_page = r.boot_page;
  assign boot_next_page = r.boot_npp;
  assign fetch_addr = r.fetch_addr;
  assign short_addr = r.short_addr;
  assign stack_ptr = r.sp;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  key_reset_fire_a: assert property (@(posedge clk) disable iff (reset)
    (r.kstate == MIM_K_COUNT && r.kcount == 26'(KEY_RESET_CYCLES - 1) && combo_held)
    |=> core_reset) else $error("key reset did not fire after hold");
  key_reset_early_a: assert property (@(posedge clk) disable iff (reset)
    $rose(core_reset) |-> $past(r.kstate) == MIM_K_COUNT)
    else $error("key reset fired without a full hold");
  boot_vector_a: assert property (@(posedge clk) disable iff (reset)
    core_reset |=> boot_step == 8'h00 && boot_page == 4'h1 && boot_next_page == 4'h1)
    else $error("boot vector wrong after reset");
  cause_clear_a: assert property (@(posedge clk) disable iff (reset)
    (rd_en && addr == `MIM_A_TM_CAUSE && !init && ct_fall[2] == 1'b0 && !ct_fall[4]
    && !ct_fall[6]) |=> r.tm_cause == 3'b000) else $error("cause not cleared by read");
  mask_reset_a: assert property (@(posedge clk) disable iff (reset)
    core_reset |=> r.key_en == 4'h0 && r.sw_en == 2'b00 && r.tm_en == 3'b000)
    else $error("enables not zero after reset");
  reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
    (rd_en && addr == `MIM_A_TM_CAUSE) |=> rdata[3] == 1'b0)
    else $error("reserved bit read as one");
  unmapped_zero_a: assert property (@(posedge clk) disable iff (reset)
    (rd_en && addr == 8'h60) |=> rdata == 4'h0) else $error("unmapped read not zero");
  short_window_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> short_addr == {4'h0, $past(short_ptr)})
    else $error("short address beyond window");
  stack_step_a: assert property (@(posedge clk) disable iff (reset)
    (stack_push && !stack_pop && !init) |=> stack_ptr == $past(stack_ptr) - 8'h03)
    else $error("push did not take three nibbles");
  dir_oe_a: assert property (@(posedge clk) disable iff (reset)
    (wr_en && addr == `MIM_A_DIR && wdata[0] && !init) |=> bidir_pins_oe_n == 4'h0)
    else $error("port not driven after output select");
  sw_clear_a: assert property (@(posedge clk) disable iff (reset)
    (wr_en && addr == `MIM_A_TIMER_CTL && wdata[0]) |=> r.sw_lo == 4'h0 && r.sw_hi == 4'h0)
    else $error("stopwatch not cleared");
endmodule : mim_io_map

/* hw/mim_pkg.sv */
package mim_pkg;
  typedef enum logic [1:0] {
    MIM_K_IDLE = 2'b00,
    MIM_K_COUNT = 2'b01,
    MIM_K_FIRED = 2'b10
  } mim_key_state_t;

  typedef enum logic [1:0] {
    MIM_R_NONE = 2'b00,
    MIM_R_RAM = 2'b01,
    MIM_R_DISP = 2'b10,
    MIM_R_IO = 2'b11
  } mim_region_t;
endpackage : mim_pkg

/* hw/mim_sync3.sv */
`timescale 1ns/10ps
module mim_sync3 #(
  parameter int WIDTH = 4
) (
  input logic clk,
  input logic reset,
  input logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import mim_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } mim_sync_t;

  mim_sync_t r;
  mim_sync_t next_r;

  if (WIDTH < 1) begin : g_chk
    $error("mim_sync3 needs WIDTH of at least 1");
  end

  // A bit only changes once the second and third stages agree.
  always_comb begin
    next_r = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.q[i] = r.s2[i];
      end
    end
    if (reset) begin
      next_r = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign dout = r.q;
endmodule : mim_sync3

/* testbench/mim_cpu_model.sv */
`timescale 1ns/10ps
module mim_cpu_model (
  input logic clk,
  output logic [7:0] addr,
  output logic rd_en,
  output logic wr_en,
  output logic [3:0] wdata,
  input logic [3:0] rdata
);
  initial begin
    addr = 8'h00;
    rd_en = 1'h0;
    wr_en = 1'h0;
    wdata = 4'h0;
  end

  // The address is inverted once released, so a stale value never looks valid.
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr

  // Read data is registered at the strobe edge, so it is taken one edge later,
  // where it is settled and still held.
  task automatic rd(input logic [7:0] a, output logic [3:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask : rd
endmodule : mim_cpu_model

/* testbench/mim_io_map_tb.sv */
`timescale 1ns/10ps
module mim_io_map_tb;
  logic clk, reset, rd_en, wr_en, supply_low_in, stack_push, stack_pop, core_reset;
  logic [7:0] addr, fetch_step, boot_step, short_addr, stack_ptr;
  logic [3:0] wdata, rdata, key_inputs, bidir_in, bidir_out, oe_n, output_pins, d;
  logic [3:0] fetch_page, boot_page, boot_np, short_ptr;
  logic [9:0] fetch_addr;
  logic hlg, sco, sds;
  int err_total, n_tests, i;
  logic [7:0] ra [12] = '{8'he2, 8'he3, 8'he8, 8'hea, 8'heb, 8'hed, 8'hee, 8'hf3,
    8'hfa, 8'hfb, 8'hfc, 8'hfd};
  logic [7:0] wa [8] = '{8'he8, 8'hea, 8'heb, 8'hf3, 8'hfb, 8'hfc, 8'hfd, 8'hfa};
  logic [3:0] we [8] = '{4'hf, 4'h3, 4'h7, 4'hf, 4'h8, 4'h1, 4'hb, 4'h9};

  mim_cpu_model u_cpu (.clk(clk), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
    .wdata(wdata), .rdata(rdata));
  mim_io_map #(.KEY_RESET_CYCLES(20), .TIMER_DIV(4), .SW_DIV(5)) u_dut (.clk(clk),
    .reset(reset), .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wdata(wdata),
    .rdata(rdata), .key_inputs(key_inputs), .bidir_pins_in(bidir_in),
    .bidir_pins_out(bidir_out), .bidir_pins_oe_n(oe_n), .supply_low_in(supply_low_in),
    .output_pins(output_pins), .heavy_load_guard(hlg), .supply_check_on(sco),
    .static_drive_select(sds), .core_reset(core_reset), .boot_step(boot_step),
    .boot_page(boot_page), .boot_next_page(boot_np), .fetch_page(fetch_page),
    .fetch_step(fetch_step), .fetch_addr(fetch_addr), .short_ptr(short_ptr),
    .short_addr(short_addr), .stack_push(stack_push), .stack_pop(stack_pop),
    .stack_ptr(stack_ptr));

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic final_report;
    $display("mismatches=%0d checks=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic wait_init;
    for (i = 0; i < 60 && core_reset !== 1'h0; i++) @(posedge clk);
    @(posedge clk);
  endtask : wait_init

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(3000 * 100);
    err_total++;
    final_report();
  end

  initial begin
    {reset, stack_push, stack_pop} = 3'h4;
    {key_inputs, bidir_in, supply_low_in, fetch_page, fetch_step, short_ptr} = 0;
    repeat (20) @(posedge clk);
    chk({boot_step, boot_page, boot_np}, 16'h0011);
    reset <= 1'h0;
    wait_init();
    for (int k = 0; k < 12; k++) begin
      u_cpu.rd(ra[k], d);
      chk(d, 4'h0);
    end
    for (int k = 0; k < 8; k++) begin
      u_cpu.wr(wa[k], 4'hf);
      u_cpu.rd(wa[k], d);
      chk(d, we[k]);
    end
    chk({hlg, sco, sds, oe_n, output_pins[3:2]}, 16'h01c3);
    u_cpu.wr(8'hf6, 4'ha);
    u_cpu.rd(8'hf6, d);
    chk({d, bidir_out}, 16'h00aa);
    u_cpu.wr(8'hf0, 4'h5);
    u_cpu.rd(8'hf0, d);
    chk(d, 4'h0);
    u_cpu.wr(8'h60, 4'h5);
    u_cpu.rd(8'h60, d);
    chk(d, 4'h0);
    u_cpu.wr(8'h0f, 4'h5);
    u_cpu.rd(8'h0f, d);
    chk(d, 4'h5);
    supply_low_in <= 1'h1;
    repeat (6) @(posedge clk);
    u_cpu.rd(8'hfa, d);
    chk(d, 4'hb);
    u_cpu.wr(8'hf9, 4'h2);
    u_cpu.rd(8'hf9, d);
    chk(d, 4'h2);
    repeat (40) @(posedge clk);
    u_cpu.rd(8'he2, d);
    chk(d < 4'ha, 1'h1);
    u_cpu.wr(8'hf9, 4'h5);
    u_cpu.rd(8'he2, d);
    chk(d, 4'h0);
    u_cpu.rd(8'hf9, d);
    chk(d, 4'h0);
    key_inputs <= 4'h1;
    repeat (8) @(posedge clk);
    u_cpu.rd(8'hed, d);
    chk(d, 4'h1);
    u_cpu.rd(8'hed, d);
    chk(d, 4'h0);
    // After a timer clear the first 32 Hz tap fall needs 8 ticks and the next
    // 32 Hz cause needs 16, so the window below sees exactly one event.
    u_cpu.wr(8'hf9, 4'h4);
    u_cpu.rd(8'hef, d);
    chk(d[3], 1'h0);
    repeat (40) @(posedge clk);
    u_cpu.rd(8'hef, d);
    chk(d, 4'h1);
    u_cpu.rd(8'hef, d);
    chk(d, 4'h0);
    u_cpu.rd(8'he4, d);
    chk(d, 4'h1);
    fetch_page <= 4'h3;
    fetch_step <= 8'h5a;
    short_ptr <= 4'hc;
    stack_push <= 1'h1;
    @(posedge clk);
    stack_push <= 1'h0;
    repeat (2) @(posedge clk);
    chk(fetch_addr, 10'h35a);
    chk({short_addr, stack_ptr}, 16'h0cfd);
    // Only this scenario raises the whole key combination at once.
    key_inputs <= 4'hf;
    repeat (10) @(posedge clk);
    chk(core_reset, 1'h0);
    repeat (40) @(posedge clk);
    chk(core_reset, 1'h1);
    key_inputs <= 4'h0;
    wait_init();
    u_cpu.rd(8'he8, d);
    chk({d, stack_ptr}, 12'h000);
    final_report();
  end
endmodule : mim_io_map_tb
